// ---- design/pspc_pkg.sv ----
// constants for the position set-point control block
package pspc_pkg;
  // ==========================================================
  // drive control word object and its field positions
  localparam logic [15:0] CTRL_WORD_INDEX = 16'h6040;
  localparam int CW_WIDTH = 16;
  localparam int POS_WIDTH = 32;
  localparam int HALT_OPT_WIDTH = 3;
  localparam int BIT_START = 4;
  localparam int BIT_IMMEDIATE = 5;
  localparam int BIT_ABS_REL = 6;
  localparam int BIT_HALT = 8;
  localparam int BIT_INCR_REF = 12;
  localparam int BIT_PUSH = 13;
  localparam int BIT_WRAP = 14;
  // ==========================================================
  // reset values
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [31:0] POS_RESET = 32'h00000000;
  localparam logic [2:0] HALT_OPT_RESET = 3'h0;
endpackage : pspc_pkg

// ---- design/pspc_top.sv ----
// position set-point control: control word interpretation for profile position moves
`timescale 1ns/1ps
module pspc_top (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CYCLE_STROBE,
  input wire logic [pspc_pkg::CW_WIDTH-1:0] CTRL_WORD,
  input wire logic [pspc_pkg::POS_WIDTH-1:0] TARGET_POS,
  input wire logic [pspc_pkg::POS_WIDTH-1:0] CMD_POS,
  input wire logic [pspc_pkg::POS_WIDTH-1:0] ACT_POS,
  input wire logic [pspc_pkg::HALT_OPT_WIDTH-1:0] HALT_OPTION,
  input wire logic EXT_STOP,
  input wire logic RUN_ENABLED,
  input wire logic MOTOR_EXCITED,
  input wire logic MOVE_DONE,
  output logic MOVE_START,
  output logic [pspc_pkg::POS_WIDTH-1:0] MOVE_TARGET,
  output logic MOVE_WRAP,
  output logic MOVE_PUSH,
  output logic MOVE_ACTIVE,
  output logic MOVE_PENDING,
  output logic START_ACK,
  output logic HALT_REQ,
  output logic [pspc_pkg::HALT_OPT_WIDTH-1:0] HALT_METHOD
);
  import pspc_pkg::*;

  // ==========================================================
  // control word sampling
  logic [CW_WIDTH-1:0] cw_q;
  logic start_edge;
  logic start_ok;
  logic accept;
  logic abort;
  logic pend_launch;
  logic [POS_WIDTH-1:0] base_pos;
  logic [POS_WIDTH-1:0] dest;
  logic [POS_WIDTH-1:0] pend_target_q;
  logic pend_wrap_q;
  logic pend_push_q;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cw_q <= CW_RESET;
    end else if (CYCLE_STROBE) begin
      cw_q <= CTRL_WORD;
    end
  end

  // edge is judged only against the previous cycle's sample, so a pulse
  // that rises and falls between two CYCLE_STROBE cycles is never seen
  assign start_edge = CYCLE_STROBE && CTRL_WORD[BIT_START] && !cw_q[BIT_START];
  // master is trusted to hold off after halt release and to settle the mode bits first
  assign start_ok = !CTRL_WORD[BIT_HALT]
                 && !EXT_STOP
                 && RUN_ENABLED
                 && MOTOR_EXCITED;
  // a refused edge is dropped for good; the master must make a fresh one
  assign accept = start_edge && start_ok;
  // any loss of permission kills both the running and the queued move
  assign abort = cw_q[BIT_HALT] || EXT_STOP || !RUN_ENABLED || !MOTOR_EXCITED;

  // ==========================================================
  // destination resolution
  // reference base only matters in relative mode
  assign base_pos = CTRL_WORD[BIT_INCR_REF] ? ACT_POS : CMD_POS;
  assign dest = CTRL_WORD[BIT_ABS_REL] ? (base_pos + TARGET_POS)
                                       : TARGET_POS;
  // completion is expected as a one-cycle pulse; a held level clears MOVE_ACTIVE after the next launch
  assign pend_launch = MOVE_PENDING && MOVE_DONE && !abort && !accept;

  // ==========================================================
  // move sequencing
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MOVE_START <= 1'b0;
      MOVE_TARGET <= POS_RESET;
      MOVE_WRAP <= 1'b0;
      MOVE_PUSH <= 1'b0;
      MOVE_ACTIVE <= 1'b0;
      MOVE_PENDING <= 1'b0;
      pend_target_q <= POS_RESET;
      pend_wrap_q <= 1'b0;
      pend_push_q <= 1'b0;
    end else begin
      MOVE_START <= 1'b0;
      // completion in the same cycle frees the engine, so an empty queue starts the new move at once
      if (accept && (!MOVE_ACTIVE || CTRL_WORD[BIT_IMMEDIATE] || (MOVE_DONE && !MOVE_PENDING))) begin
        MOVE_START <= 1'b1;
        MOVE_TARGET <= dest;
        MOVE_WRAP <= CTRL_WORD[BIT_WRAP];
        MOVE_PUSH <= CTRL_WORD[BIT_PUSH];
        MOVE_ACTIVE <= 1'b1;
        MOVE_PENDING <= 1'b0;
      end else if (accept) begin
        MOVE_PENDING <= 1'b1;
        pend_target_q <= dest;
        pend_wrap_q <= CTRL_WORD[BIT_WRAP];
        pend_push_q <= CTRL_WORD[BIT_PUSH];
        // completion with a move already queued: that one goes now, the new one waits
        if (MOVE_DONE) begin
          MOVE_START <= 1'b1;
          MOVE_TARGET <= pend_target_q;
          MOVE_WRAP <= pend_wrap_q;
          MOVE_PUSH <= pend_push_q;
        end
      end else if (abort) begin
        MOVE_ACTIVE <= 1'b0;
        MOVE_PENDING <= 1'b0;
      end else if (pend_launch) begin
        MOVE_START <= 1'b1;
        MOVE_TARGET <= pend_target_q;
        MOVE_WRAP <= pend_wrap_q;
        MOVE_PUSH <= pend_push_q;
        MOVE_PENDING <= 1'b0;
      end else if (MOVE_DONE) begin
        MOVE_ACTIVE <= 1'b0;
      end
    end
  end

  // ==========================================================
  // set-point acknowledge; set wins over clear
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      START_ACK <= 1'b0;
    end else if (accept) begin
      START_ACK <= 1'b1;
    end else if (!cw_q[BIT_START] || !RUN_ENABLED) begin
      START_ACK <= 1'b0;
    end
  end

  // ==========================================================
  // halt request toward the motion engine
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HALT_REQ <= 1'b0;
      HALT_METHOD <= HALT_OPT_RESET;
    end else begin
      HALT_REQ <= cw_q[BIT_HALT];
      // method frozen while halted so a mid-stop change cannot alter the ramp
      if (!cw_q[BIT_HALT]) begin
        HALT_METHOD <= HALT_OPTION;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  sequence s_accept_idle;
    accept && !MOVE_ACTIVE;
  endsequence

  sequence s_accept_busy;
    accept && MOVE_ACTIVE;
  endsequence

  sequence s_accept_done;
    accept && MOVE_ACTIVE && MOVE_DONE && !CTRL_WORD[BIT_IMMEDIATE];
  endsequence

  chk_abs_target: assert property (s_accept_idle and (!CTRL_WORD[BIT_ABS_REL]) |=>
    MOVE_START && MOVE_TARGET == $past(TARGET_POS)) else $error("absolute goal not passed through");
  chk_rel_target: assert property (s_accept_idle and (CTRL_WORD[BIT_ABS_REL] && !CTRL_WORD[BIT_INCR_REF]) |=>
    MOVE_TARGET == $past(CMD_POS) + $past(TARGET_POS)) else $error("relative goal not added to base");
  chk_buffered_start: assert property (s_accept_busy and (!CTRL_WORD[BIT_IMMEDIATE] && !MOVE_DONE) |=>
    !MOVE_START && MOVE_PENDING) else $error("buffered start not queued");
  chk_pending_launch: assert property (pend_launch |=> MOVE_START && !MOVE_PENDING
    && MOVE_TARGET == $past(pend_target_q)) else $error("queued move not launched");
  chk_immediate_start: assert property (s_accept_busy and (CTRL_WORD[BIT_IMMEDIATE]) |=>
    MOVE_START ##1 !MOVE_START) else $error("immediate start not applied");
  chk_edge_only: assert property (MOVE_START && !$past(pend_launch) |-> $past(start_edge))
    else $error("move began without start edge");
  chk_halt_blocks: assert property (start_edge && CTRL_WORD[BIT_HALT] && !pend_launch |=> !MOVE_START)
    else $error("start taken while halted");
  chk_stop_blocks: assert property (start_edge && EXT_STOP |=> !MOVE_START && !$rose(START_ACK))
    else $error("start taken while stop active");
  chk_run_blocks: assert property (start_edge && !RUN_ENABLED |=> !MOVE_START)
    else $error("start taken outside run state");
  chk_excite_blocks: assert property (start_edge && !MOTOR_EXCITED |=> !MOVE_START)
    else $error("start taken with motor unexcited");
  chk_ack_set: assert property (accept |=> START_ACK) else $error("ack not set on accept");
  chk_ack_clear: assert property (!RUN_ENABLED |=> !START_ACK) else $error("ack held outside run state");
  chk_halt_stops: assert property (cw_q[BIT_HALT] && !accept |=> !MOVE_ACTIVE ##0 HALT_REQ)
    else $error("halt did not stop move");
  chk_cycle_sample: assert property (CYCLE_STROBE |=> cw_q == $past(CTRL_WORD))
    else $error("control word not sampled");
  chk_done_handover: assert property (s_accept_done |=> MOVE_START && MOVE_ACTIVE)
    else $error("start lost at move completion");
  chk_queue_flush: assert property (s_accept_busy and (CTRL_WORD[BIT_IMMEDIATE]) |=> !MOVE_PENDING)
    else $error("queued move kept after immediate start");
  chk_mode_capture: assert property (s_accept_idle |=> MOVE_WRAP == $past(CTRL_WORD[BIT_WRAP])
    && MOVE_PUSH == $past(CTRL_WORD[BIT_PUSH])) else $error("wrap or push not captured");
  chk_ack_drop: assert property (!cw_q[BIT_START] && !accept |=> !START_ACK)
    else $error("ack held after start bit cleared");
  chk_abort_clears: assert property (abort && !accept |=> !MOVE_ACTIVE && !MOVE_PENDING)
    else $error("move kept after abort");
  chk_method_hold: assert property (cw_q[BIT_HALT] |=> HALT_METHOD == $past(HALT_METHOD))
    else $error("halt method changed while halted");
  chk_halt_follow: assert property (1'b1 |=> HALT_REQ == $past(cw_q[BIT_HALT]))
    else $error("halt request does not follow sample");
endmodule : pspc_top

// ---- tb/pspc_master.sv ----
// fieldbus master model writing the drive control word each cycle
`timescale 1ns/1ps
module pspc_master (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] want_word,
  output logic strobe,
  output logic [15:0] ctrl_word
);
  logic [1:0] div_q;
  logic [1:0] hold_q;
  logic rel;
  logic early;
  // ==========================================================
  // one write every four clocks; start bit held back when unsafe
  assign rel = ctrl_word[8] & ~want_word[8];
  assign early = rel || hold_q != 2'h0 || ((want_word ^ ctrl_word) & 16'h7040) != 16'h0000;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 2'h0;
      strobe <= 1'b0;
      ctrl_word <= 16'h0000;
      hold_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
      strobe <= div_q == 2'h3;
      if (div_q == 2'h3) begin
        hold_q <= rel ? 2'h3 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
        ctrl_word <= (want_word[4] && !ctrl_word[4] && early) ? (want_word & 16'hFFEF) : want_word;
      end
    end
  end
endmodule : pspc_master

// ---- tb/test_pspc_top.sv ----
// testbench for the position set-point control block
`timescale 1ns/1ps
module test_pspc_top;
  import pspc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic stb;
  logic [15:0] cw;
  logic [15:0] w = 16'h0000;
  logic [31:0] tgt = 32'h0, cmd = 32'h0, act = 32'h0, mt;
  logic [2:0] hopt = 3'h5, hm;
  logic stop = 1'b0, run = 1'b1, exc = 1'b1, done = 1'b0;
  logic ms, wr, pu, actv, pend, ack, hr;
  int err_total = 0;
  int check_count = 0;
  int starts = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (ms === 1'b1) starts <= starts + 1;
  pspc_master master (.mclk(mclk), .reset_n(rst_n), .want_word(w), .strobe(stb), .ctrl_word(cw));
  pspc_top uut (.MCLK(mclk), .RESET_N(rst_n), .CYCLE_STROBE(stb), .CTRL_WORD(cw), .TARGET_POS(tgt),
    .CMD_POS(cmd), .ACT_POS(act), .HALT_OPTION(hopt), .EXT_STOP(stop), .RUN_ENABLED(run),
    .MOTOR_EXCITED(exc), .MOVE_DONE(done), .MOVE_START(ms), .MOVE_TARGET(mt), .MOVE_WRAP(wr),
    .MOVE_PUSH(pu), .MOVE_ACTIVE(actv), .MOVE_PENDING(pend), .START_ACK(ack), .HALT_REQ(hr), .HALT_METHOD(hm));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // six writes cover the model's hold-off after a halt release
  task put(input logic [15:0] v);
    int n;
    int t;
    w <= v;
    n = 0;
    for (t = 0; t < 200 && n < 6; t++) begin
      @(posedge mclk);
      if (stb === 1'b1) n++;
    end
    if (n < 6) begin
      err_total++;
      close_out();
    end
    @(posedge mclk);
  endtask : put
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    tgt <= 32'h00000100;
    put(16'h0010);
    chk("target", mt, 32'h00000100);
    chk("starts", starts, 32'h1);
    chk("ack", ack, 32'h1);
    tgt <= 32'h00000200;
    put(16'h0000);
    chk("ack", ack, 32'h0);
    put(16'h0010);
    chk("pending", pend, 32'h1);
    chk("starts", starts, 32'h1);
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("target", mt, 32'h00000200);
    chk("starts", starts, 32'h2);
    chk("pending", pend, 32'h0);
    $display("test abs and buffered done");
    tgt <= 32'h00000300;
    put(16'h0000);
    put(16'h0030);
    chk("target", mt, 32'h00000300);
    chk("starts", starts, 32'h3);
    cmd <= 32'h000003E8;
    act <= 32'h000007D0;
    tgt <= 32'h0000000A;
    put(16'h0000);
    put(16'h0070);
    chk("target", mt, 32'h000003F2);
    put(16'h0000);
    put(16'h1070);
    chk("target", mt, 32'h000007DA);
    $display("test immediate and relative done");
    put(16'h0100);
    chk("halt", hr, 32'h1);
    chk("active", actv, 32'h0);
    chk("method", hm, 32'h5);
    put(16'h0110);
    chk("starts", starts, 32'h5);
    put(16'h0100);
    put(16'h0010);
    chk("starts", starts, 32'h6);
    chk("halt", hr, 32'h0);
    $display("test halt done");
    for (int i = 0; i < 3; i++) begin
      put(16'h0000);
      stop <= i == 0;
      run <= i != 1;
      exc <= i != 2;
      put(16'h0010);
      chk("starts", starts, 32'h6);
      stop <= 1'b0;
      run <= 1'b1;
      exc <= 1'b1;
    end
    $display("test refusals done");
    put(16'h0000);
    put(16'h6010);
    chk("wrap", wr, 32'h1);
    chk("push", pu, 32'h1);
    chk("target", mt, 32'h0000000A);
    run <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("ack", ack, 32'h0);
    chk("active", actv, 32'h0);
    run <= 1'b1;
    rst_n <= 1'b0;
    w <= 16'h0000;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    put(16'h0010);
    chk("starts", starts, 32'h8);
    chk("wrap", wr, 32'h0);
    chk("push", pu, 32'h0);
    chk("ack", ack, 32'h1);
    $display("test mode bits and restart done");
    close_out();
  end
endmodule : test_pspc_top
